// File: hdl/sdd_cfg.svh
`ifndef SDD_CFG_SVH
`define SDD_CFG_SVH
// word framing
`define SDD_LAST_PHASE 4'h9
`define SDD_MID_PHASE 4'h4
`define SDD_FIRST_PHASE 4'h0
// descrambler taps into the received-bit history (x^4 and x^9)
`define SDD_TAP_X4 3
`define SDD_TAP_X9 8
// timing reference preamble and the end/start bit of the xyz word
`define SDD_PRE_ONES 10'h3FF
`define SDD_PRE_ZERO 10'h000
`define SDD_XYZ_EAV_BIT 6
// output burst length of the timing reference flag, in words
`define SDD_TRS_WORDS 3'h4
// positions in the synchroniser vector
`define SDD_IN_SDATA 0
`define SDD_IN_SCLK 1
`define SDD_IN_NRZI 2
`define SDD_IN_DESCRAMBLE_ENABLE 3
`define SDD_IN_FE 4
// register byte addresses
`define SDD_ADR_CTRL 4'h0
`define SDD_ADR_STAT 4'h4
`define SDD_ADR_MASK 4'h8
`define SDD_ADR_STATE 4'hC
// register reset values and field positions
`define SDD_CTRL_RST 1'h0
`define SDD_STAT_RST 4'h0
`define SDD_MASK_RST 4'h0
`define SDD_CTRL_COMPOSITE 0
`endif

// File: hdl/sdd_pkg.sv
`include "sdd_cfg.svh"
package sdd_pkg;
  // one parallel word on its way to the outputs, with its flags
  typedef struct packed {
    logic [9:0] word;
    logic trs;
    logic xyz;
  } sdd_word_type;
  // sticky event layout: bit 0 is trs
  typedef struct packed {
    logic resync;
    logic newPos;
    logic eav;
    logic trs;
  } sdd_event_type;
  typedef enum logic {ALIGN_HELD, ALIGN_MOVED} sdd_align_type;
  function automatic logic sdd_is_eav(input logic [9:0] w);
    return w[`SDD_XYZ_EAV_BIT];
  endfunction : sdd_is_eav
endpackage : sdd_pkg

// File: hdl/sdd_line_decode.sv
`timescale 1ns/1ps
`include "sdd_cfg.svh"
module sdd_line_decode (
  input wire logic clk,
  input wire logic srst,
  input wire logic bitIn,
  input wire logic bitStb,
  input wire logic nrziEnable,
  input wire logic descrambleEnable,
  output logic decBit,
  output logic decStb
);
  logic prevQ, prevD, decBitQ, decBitD, decStbQ;
  logic [8:0] histQ, histD;
  logic nrz;
  // nrzi undo, then self-synchronising descramble on received nrz bits
  always_comb begin
    nrz = nrziEnable ? (bitIn ^ prevQ) : bitIn;
    prevD = prevQ;
    histD = histQ;
    decBitD = decBitQ;
    if (bitStb) begin
      prevD = bitIn;
      histD = {histQ[7:0], nrz};
      decBitD = descrambleEnable ? (nrz ^ histQ[`SDD_TAP_X4] ^ histQ[`SDD_TAP_X9]) : nrz;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      prevQ <= 1'b0;
      histQ <= 9'h000;
      decBitQ <= 1'b0;
      decStbQ <= 1'b0;
    end else begin
      prevQ <= prevD;
      histQ <= histD;
      decBitQ <= decBitD;
      decStbQ <= bitStb;
    end
  end
  assign decBit = decBitQ;
  assign decStb = decStbQ;
  plain_pass_a: assert property (@(posedge clk) disable iff (srst)
    bitStb && !nrziEnable && !descrambleEnable |=> decStb && decBit == $past(bitIn))
    else $error("bit not passed through unchanged");
  descramble_a: assert property (@(posedge clk) disable iff (srst)
    bitStb && descrambleEnable |=> decStb &&
      decBit == ($past(nrz) ^ $past(histQ[`SDD_TAP_X4]) ^ $past(histQ[`SDD_TAP_X9])))
    else $error("descrambled bit wrong");
endmodule : sdd_line_decode

// File: hdl/sdd_trs_match.sv
`timescale 1ns/1ps
`include "sdd_cfg.svh"
module sdd_trs_match (
  input wire logic [29:0] window,
  output logic hit
);
  // oldest word sits lowest, since bits arrive lsb first; any bit offset
  assign hit = (window[9:0] == `SDD_PRE_ONES) &&
    (window[19:10] == `SDD_PRE_ZERO) && (window[29:20] == `SDD_PRE_ZERO);
endmodule : sdd_trs_match

// File: hdl/sdd_decoder.sv
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sdd_cfg.svh"
module sdd_decoder (
  input wire logic clk,
  input wire logic srst,
  input wire logic serialDataIn,
  input wire logic serialClockIn,
  input wire logic nrziEnable,
  input wire logic descrambleEnable,
  input wire logic framingEnable,
  output logic [9:0] parallelWordOut,
  output logic wordClockOut,
  output logic trsFlagN,
  output logic eavFlagN,
  output logic newSyncPositionFlag,
  output logic irq,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  logic [4:0] meta1Q, meta2Q;
  logic sclkLastQ;
  logic bitStb;
  logic decBit, decStb, trsHit;
  logic [29:0] shiftQ, shiftD;
  logic [3:0] phaseQ, phaseD;
  sdd_pkg::sdd_align_type alignQ, alignD;
  sdd_pkg::sdd_word_type pipeQ [0:2];
  sdd_pkg::sdd_word_type pipeD [0:2];
  sdd_pkg::sdd_word_type newEntry;
  sdd_pkg::sdd_event_type evt;
  logic xyzPendQ, xyzPendD;
  logic [9:0] wordOutQ, wordOutD;
  logic wordClkQ, wordClkD;
  logic trsNQ, trsND, eavNQ, eavND, nspQ, nspD;
  logic [2:0] trsRunQ, trsRunD;
  logic wordDone, realign, xyzEav;
  logic ctrlQ, ctrlD;
  logic [3:0] statQ, statD, maskQ, maskD;
  logic irqQ, irqD, ackQ, ackD;
  logic [31:0] datQ, datD;
  logic busReq, busWr;

  // word-end test, shared by the framing logic and its checks
  function automatic logic sdd_at_word_end(input logic [3:0] phase);
    return phase == `SDD_LAST_PHASE;
  endfunction : sdd_at_word_end

  // pins cross into clk through two flops; nothing reads meta1Q but meta2Q
  // data and serial clock share both flops, so their relative timing survives
  always_ff @(posedge clk) begin
    if (srst) begin
      meta1Q <= 5'h00;
      meta2Q <= 5'h00;
      sclkLastQ <= 1'b0;
    end else begin
      meta1Q <= {framingEnable, descrambleEnable, nrziEnable, serialClockIn, serialDataIn};
      meta2Q <= meta1Q;
      sclkLastQ <= meta2Q[`SDD_IN_SCLK];
    end
  end

  // serial data taken at the synced rising serial clock edge
  // a serial clock above about half of clk would lose edges here
  assign bitStb = meta2Q[`SDD_IN_SCLK] & ~sclkLastQ;

  sdd_line_decode u_line (
    .clk(clk),
    .srst(srst),
    .bitIn(meta2Q[`SDD_IN_SDATA]),
    .bitStb(bitStb),
    .nrziEnable(meta2Q[`SDD_IN_NRZI]),
    .descrambleEnable(meta2Q[`SDD_IN_DESCRAMBLE_ENABLE]),
    .decBit(decBit),
    .decStb(decStb)
  );

  sdd_trs_match u_match (
    .window(shiftD),
    .hit(trsHit)
  );

  // framing, alignment state and the three-word output pipeline
  always_comb begin
    shiftD = shiftQ;
    phaseD = phaseQ;
    alignD = alignQ;
    pipeD = pipeQ;
    xyzPendD = xyzPendQ;
    wordOutD = wordOutQ;
    wordClkD = wordClkQ;
    trsND = trsNQ;
    eavND = eavNQ;
    trsRunD = trsRunQ;
    newEntry = '0;
    evt = '0;
    wordDone = 1'b0;
    realign = 1'b0;
    xyzEav = 1'b0;
    if (decStb) begin
      shiftD = {decBit, shiftQ[29:1]};
      if (trsHit) begin
        evt.trs = 1'b1;
        if (sdd_at_word_end(phaseQ)) begin
          alignD = sdd_pkg::ALIGN_HELD;
        end else begin
          evt.newPos = 1'b1;
          if (meta2Q[`SDD_IN_FE]) begin
            // second miss in a row (tied mode) clears, a first one marks
            realign = 1'b1;
            evt.resync = 1'b1;
            alignD = (alignQ == sdd_pkg::ALIGN_MOVED) ? sdd_pkg::ALIGN_HELD :
              sdd_pkg::ALIGN_MOVED;
          end else begin
            alignD = sdd_pkg::ALIGN_MOVED;
          end
        end
      end
      wordDone = sdd_at_word_end(phaseQ) || realign;
      if (wordDone) begin
        phaseD = `SDD_FIRST_PHASE;
        newEntry.word = shiftD[29:20];
        newEntry.trs = trsHit | xyzPendQ;
        newEntry.xyz = xyzPendQ;
        xyzPendD = trsHit;
        pipeD[0] = newEntry;
        pipeD[1] = pipeQ[0];
        pipeD[2] = pipeQ[1];
        if (trsHit) begin
          // in phase, the two earlier preamble words are still in the pipeline
          pipeD[1].trs = 1'b1;
          pipeD[2].trs = 1'b1;
        end
        // three words of delay let the flag cover the whole preamble
        wordOutD = pipeQ[2].word;
        trsND = ~pipeQ[2].trs;
        xyzEav = pipeQ[2].xyz & sdd_pkg::sdd_is_eav(pipeQ[2].word);
        eavND = ~(xyzEav & ~ctrlQ);
        evt.eav = xyzEav & ~ctrlQ;
        wordClkD = 1'b0;
        if (!pipeQ[2].trs) begin
          trsRunD = 3'h0;
        end else if (trsRunQ != 3'h7) begin
          trsRunD = 3'(trsRunQ + 3'h1);
        end
      end else begin
        phaseD = 4'(phaseQ + 4'h1);
        if (phaseQ == `SDD_MID_PHASE) begin
          wordClkD = 1'b1;
        end
      end
    end
    if (ctrlQ) begin
      eavND = 1'b1;
    end
    nspD = (alignD == sdd_pkg::ALIGN_MOVED);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shiftQ <= 30'h00000000;
      phaseQ <= `SDD_FIRST_PHASE;
      alignQ <= sdd_pkg::ALIGN_HELD;
      pipeQ <= '{default: '0};
      xyzPendQ <= 1'b0;
      wordOutQ <= 10'h000;
      wordClkQ <= 1'b0;
      trsNQ <= 1'b1;
      eavNQ <= 1'b1;
      nspQ <= 1'b0;
      trsRunQ <= 3'h0;
    end else begin
      shiftQ <= shiftD;
      phaseQ <= phaseD;
      alignQ <= alignD;
      pipeQ <= pipeD;
      xyzPendQ <= xyzPendD;
      wordOutQ <= wordOutD;
      wordClkQ <= wordClkD;
      trsNQ <= trsND;
      eavNQ <= eavND;
      nspQ <= nspD;
      trsRunQ <= trsRunD;
    end
  end

  // wishbone slave: ack one cycle after the strobe, dropped a cycle later
  assign busReq = cyc_i & stb_i & ~ackQ;
  assign busWr = busReq & we_i & sel_i[0];

  always_comb begin
    ackD = busReq;
    ctrlD = ctrlQ;
    maskD = maskQ;
    // events set over a clear in the same cycle, so none is lost
    statD = statQ | evt;
    datD = 32'h00000000;
    if (busWr && adr_i == `SDD_ADR_CTRL) begin
      ctrlD = dat_i[`SDD_CTRL_COMPOSITE];
    end
    if (busWr && adr_i == `SDD_ADR_MASK) begin
      maskD = dat_i[3:0];
    end
    if (busWr && adr_i == `SDD_ADR_STAT) begin
      statD = (statQ & ~dat_i[3:0]) | evt;
    end
    if (busReq && !we_i) begin
      unique case (adr_i)
        `SDD_ADR_CTRL: datD = {31'h00000000, ctrlQ};
        `SDD_ADR_STAT: datD = {28'h0000000, statQ};
        `SDD_ADR_MASK: datD = {28'h0000000, maskQ};
        `SDD_ADR_STATE: datD = {23'h000000, alignQ == sdd_pkg::ALIGN_MOVED,
          xyzPendQ, wordClkQ, trsNQ, eavNQ, phaseQ};
        default: datD = 32'h00000000;
      endcase
    end
    irqD = |(statD & maskD);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ackQ <= 1'b0;
      ctrlQ <= `SDD_CTRL_RST;
      maskQ <= `SDD_MASK_RST;
      statQ <= `SDD_STAT_RST;
      datQ <= 32'h00000000;
      irqQ <= 1'b0;
    end else begin
      ackQ <= ackD;
      ctrlQ <= ctrlD;
      maskQ <= maskD;
      statQ <= statD;
      datQ <= datD;
      irqQ <= irqD;
    end
  end

  assign parallelWordOut = wordOutQ;
  assign wordClockOut = wordClkQ;
  assign trsFlagN = trsNQ;
  assign eavFlagN = eavNQ;
  assign newSyncPositionFlag = nspQ;
  assign irq = irqQ;
  assign dat_o = datQ;
  assign ack_o = ackQ;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence sRefInPhase;
    decStb && trsHit && sdd_at_word_end(phaseQ);
  endsequence
  sequence sRefMoved;
    decStb && trsHit && !sdd_at_word_end(phaseQ);
  endsequence

  trs_four_words_a: assert property (
    wordDone && !pipeQ[2].trs && trsRunQ != 3'h0 |-> trsRunQ == `SDD_TRS_WORDS)
    else $error("trs flag burst not four words");
  trs_covers_ref_a: assert property (
    sRefInPhase |=> pipeQ[0].trs && pipeQ[1].trs && pipeQ[2].trs &&
      pipeQ[2].word == `SDD_PRE_ONES)
    else $error("preamble words not flagged");
  eav_in_trs_a: assert property (
    $fell(eavFlagN) |-> !trsFlagN ##1 !ctrlQ || eavFlagN)
    else $error("eav pulse outside the reference");
  composite_eav_a: assert property (
    ctrlQ |=> eavFlagN)
    else $error("eav low in composite mode");
  nsp_raise_a: assert property (
    sRefMoved ##0 alignQ == sdd_pkg::ALIGN_HELD |=> newSyncPositionFlag)
    else $error("new sync flag not raised");
  nsp_clear_a: assert property (
    sRefInPhase |=> !newSyncPositionFlag)
    else $error("new sync flag not cleared by aligned ref");
  phase_kept_a: assert property (
    sRefMoved ##0 !meta2Q[`SDD_IN_FE] |=> phaseQ == 4'($past(phaseQ) + 4'h1))
    else $error("phase moved with framing disabled");
  realign_now_a: assert property (
    sRefMoved ##0 meta2Q[`SDD_IN_FE] |=> phaseQ == `SDD_FIRST_PHASE && !wordClockOut)
    else $error("no realignment with framing enabled");
  second_miss_a: assert property (
    sRefMoved ##0 meta2Q[`SDD_IN_FE] && alignQ == sdd_pkg::ALIGN_MOVED
      |=> !newSyncPositionFlag)
    else $error("second miss did not clear flag");
  clock_mid_a: assert property (
    $rose(wordClockOut) |-> phaseQ == 4'(`SDD_MID_PHASE + 4'h1))
    else $error("word clock not mid word");
  ack_single_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

  // bus, status and interrupt checks; read data shows only in the ack cycle
  bus_answer_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  data_idle_zero_a: assert property (
    !ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside the ack cycle");
  irq_level_a: assert property (
    irq == |(statQ & maskQ))
    else $error("irq does not follow status and mask");
  event_sticky_a: assert property (
    evt.trs |=> statQ[0])
    else $error("reference event lost");

  // word clock, end-of-active pulse and output word, counted in word ends
  sequence sWordEnd;
    decStb && wordDone;
  endsequence
  word_clock_fall_a: assert property (
    sWordEnd |=> !wordClockOut)
    else $error("word clock high at a new word");
  eav_one_word_a: assert property (
    sWordEnd ##0 !eavFlagN |=> eavFlagN)
    else $error("eav pulse longer than one word");
  word_held_a: assert property (
    !(decStb && wordDone) |=> $stable(parallelWordOut))
    else $error("word changed between word ends");
endmodule : sdd_decoder

// File: sim/sdd_serial_source.sv
`timescale 1ns/1ps
module sdd_serial_source (
  input wire logic clk,
  input wire logic scrambleOn,
  input wire logic nrziOn,
  output logic serialData,
  output logic serialClock
);
  logic [8:0] histQ;
  logic lineQ;
  // clock parked low between frames, so no stray bit is ever sampled
  initial begin
    histQ = 9'h000;
    lineQ = 1'b0;
    serialData <= 1'b0;
    serialClock <= 1'b0;
  end
  // one bit per 8 clk cycles (80 ns); rising edge well inside the data eye
  task automatic sendBit(input logic b);
    logic s;
    s = scrambleOn ? (b ^ histQ[3] ^ histQ[8]) : b;
    histQ = {histQ[7:0], s};
    lineQ = nrziOn ? (lineQ ^ s) : s;
    serialData <= lineQ;
    repeat (2) @(posedge clk);
    serialClock <= 1'b1;
    repeat (4) @(posedge clk);
    serialClock <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : sendBit
  // lsb first; the line keeps its last level, the parked clock marks it idle
  task automatic sendWord(input logic [9:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      sendBit(w[i]);
    end
  endtask : sendWord
endmodule : sdd_serial_source

// File: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin failCount++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
  typedef struct {
    logic nrzi;
    logic descramble_enable;
    logic comp;
    logic [9:0] xyz;
    logic eav;
  } sdd_row_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic nrziEnable = 1'b1;
  logic descrambleEnable = 1'b1;
  logic feSet = 1'b1;
  logic tieMode = 1'b0;
  logic framingEnable = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbAdr = 4'h0;
  logic [31:0] wbDatW = 32'h0000_0000;
  logic serialDataIn, serialClockIn, wordClockOut, trsFlagN, eavFlagN;
  logic newSyncPositionFlag, irq, ackO;
  logic wcPrev = 1'b0;
  logic [9:0] parallelWordOut;
  logic [31:0] datO, rd;
  logic [9:0] trsWords [$];
  int eavCnt = 0;
  int failCount = 0;
  int nTests = 0;
  sdd_row_type rows [5] = '{
    '{1'b1, 1'b1, 1'b0, 10'h274, 1'b1}, '{1'b1, 1'b1, 1'b0, 10'h200, 1'b0},
    '{1'b1, 1'b1, 1'b1, 10'h274, 1'b0}, '{1'b0, 1'b0, 1'b0, 10'h274, 1'b1},
    '{1'b1, 1'b0, 1'b0, 10'h2D8, 1'b1}};
  // 100 MHz system clock
  initial begin
    forever #5 clk = ~clk;
  end
  sdd_decoder dut_u (.clk(clk), .srst(srst), .serialDataIn(serialDataIn),
    .serialClockIn(serialClockIn), .nrziEnable(nrziEnable),
    .descrambleEnable(descrambleEnable), .framingEnable(framingEnable),
    .parallelWordOut(parallelWordOut), .wordClockOut(wordClockOut), .trsFlagN(trsFlagN),
    .eavFlagN(eavFlagN), .newSyncPositionFlag(newSyncPositionFlag), .irq(irq),
    .cyc_i(wbCyc), .stb_i(wbStb), .we_i(wbWe), .adr_i(wbAdr), .sel_i(4'hF),
    .dat_i(wbDatW), .dat_o(datO), .ack_o(ackO));
  sdd_serial_source src (.clk(clk), .scrambleOn(descrambleEnable), .nrziOn(nrziEnable),
    .serialData(serialDataIn), .serialClock(serialClockIn));
  // tied mode feeds the new-position flag back as framing enable
  always @(posedge clk) begin
    framingEnable <= tieMode ? newSyncPositionFlag : feSet;
  end
  // capture flagged words at each word clock rise, when outputs are settled
  always @(posedge clk) begin
    if (wordClockOut === 1'b1 && wcPrev === 1'b0) begin
      if (trsFlagN === 1'b0) trsWords.push_back(parallelWordOut);
      if (eavFlagN === 1'b0) eavCnt++;
    end
    wcPrev = wordClockOut;
  end
  task automatic stopTest;
    $display("checks %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stopTest
  // single classic cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int i;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ackO === 1'b1) break;
    end
    if (i == 20) begin
      failCount++;
      stopTest();
    end
    q = datO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // lead-in lets descrambler and line decoder settle; trailer flushes the pipe
  task automatic frame(input logic [9:0] xyz);
    trsWords.delete();
    eavCnt = 0;
    repeat (4) src.sendWord(10'h200, 10);
    src.sendWord(10'h3FF, 10);
    src.sendWord(10'h000, 10);
    src.sendWord(10'h000, 10);
    src.sendWord(xyz, 10);
    repeat (5) src.sendWord(10'h200, 10);
    repeat (4) @(posedge clk);
  endtask : frame
  task automatic checkWords(input logic [9:0] xyz);
    logic [9:0] expW [4];
    expW = '{10'h3FF, 10'h000, 10'h000, xyz};
    `CHK(trsWords.size(), 4)
    for (int k = 0; k < 4; k++) begin
      `CHK(trsWords[k], expW[k])
    end
  endtask : checkWords
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK(trsFlagN, 1'b1)
    `CHK(eavFlagN, 1'b1)
    `CHK(newSyncPositionFlag, 1'b0)
    `CHK(irq, 1'b0)
    wb(1'b1, 4'h2, 32'h0000_00FF, rd);
    wb(1'b0, 4'h2, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    for (int a = 0; a < 3; a++) begin
      wb(1'b0, 4'(a * 4), 32'h0000_0000, rd);
      `CHK(rd, 32'h0000_0000)
    end
    frame(10'h274);
    $display("test reset done");
    foreach (rows[i]) begin
      nrziEnable <= rows[i].nrzi;
      descrambleEnable <= rows[i].descramble_enable;
      wb(1'b1, 4'h0, {31'h0, rows[i].comp}, rd);
      wb(1'b1, 4'h4, 32'h0000_000F, rd);
      frame(rows[i].xyz);
      checkWords(rows[i].xyz);
      `CHK(eavCnt, rows[i].eav ? 1 : 0)
      wb(1'b0, 4'h4, 32'h0000_0000, rd);
      `CHK(rd[1:0], {rows[i].eav, 1'b1})
      `CHK(irq, 1'b0)
      $display("test row %0d done", i);
    end
    // unmask the reference event, then clear it
    wb(1'b1, 4'h8, 32'h0000_0001, rd);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wb(1'b1, 4'h4, 32'h0000_0001, rd);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wb(1'b0, 4'h4, 32'h0000_0000, rd);
    `CHK(rd[0], 1'b0)
    $display("test irq done");
    // framing held: stray position flagged, in-phase reference clears it
    feSet <= 1'b0;
    src.sendWord(10'h000, 1);
    frame(10'h274);
    `CHK(newSyncPositionFlag, 1'b1)
    src.sendWord(10'h000, 9);
    frame(10'h274);
    `CHK(newSyncPositionFlag, 1'b0)
    checkWords(10'h274);
    $display("test hold done");
    // framing enabled: shifted reference realigns the words
    feSet <= 1'b1;
    src.sendWord(10'h000, 5);
    frame(10'h274);
    frame(10'h274);
    checkWords(10'h274);
    // tied mode: first stray ignored, second realigns and clears
    tieMode <= 1'b1;
    src.sendWord(10'h000, 3);
    frame(10'h274);
    `CHK(newSyncPositionFlag, 1'b1)
    frame(10'h274);
    `CHK(newSyncPositionFlag, 1'b0)
    frame(10'h274);
    checkWords(10'h274);
    $display("test framing done");
    // mid-run reset: outputs and registers return to their reset values
    wb(1'b1, 4'h8, 32'h0000_000F, rd);
    `CHK(irq, 1'b1)
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK(trsFlagN, 1'b1)
    `CHK(eavFlagN, 1'b1)
    `CHK(newSyncPositionFlag, 1'b0)
    `CHK(wordClockOut, 1'b0)
    `CHK(parallelWordOut, 10'h000)
    `CHK(irq, 1'b0)
    wb(1'b0, 4'h8, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    wb(1'b0, 4'hC, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0030)
    $display("test midrun reset done");
    stopTest();
  end
endmodule : tb_top
